//--- src/ebl_pkg.sv
package ebl_pkg;

  // ==========================================================
  // Access sizes
  typedef enum logic [1:0] {
    SZ_BYTE  = 2'h0,
    SZ_HALF  = 2'h1,
    SZ_WORD  = 2'h2,
    SZ_BURST = 2'h3
  } ebl_size_t;

  // ==========================================================
  // Core request carrier
  typedef struct packed {
    logic        write;
    ebl_size_t   size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ebl_req_t;

  // ==========================================================
  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_ADDR   = 6'h02,
    ST_SINGLE = 6'h04,
    ST_WORD1  = 6'h08,
    ST_WORD2  = 6'h10,
    ST_BURST  = 6'h20
  } ebl_state_t;

  // ==========================================================
  // Constants
  localparam logic [3:0] LANES_OFF          = 4'hF;
  localparam logic [3:0] LANES_ALL          = 4'h0;
  localparam logic [3:0] LANES_HALF_LO      = 4'hC;
  localparam logic [3:0] LANES_HALF_HI      = 4'h3;
  localparam logic [3:0] LANE_ONE           = 4'h1;
  localparam logic [2:0] WIDE_BURST_LAST    = 3'h3;
  localparam logic [2:0] NARROW_BURST_LAST  = 3'h7;
  localparam logic [1:0] CFG_SETTLE         = 2'h2;
  localparam int         FIFO_WIDTH         = 32;
  localparam int         FIFO_DEPTH         = 32;
  localparam int         FIFO_LVL_W         = 6;
  localparam logic [5:0] FIFO_ROOM_LIMIT    = 6'h1B;
  localparam logic [31:0] WORD_ZERO         = 32'h0000_0000;
  localparam logic [15:0] HALF_ZERO         = 16'h0000;

endpackage

//--- src/ebl_fifo.sv
`timescale 1ns/1ps
module ebl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int LVL_W = 6
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [LVL_W-1:0]      level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [LVL_W-1:0] count_reg;
  logic             out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;

  // ==========================================================
  // Handshakes; output stage is a register so the top sees flops everywhere but in_ready
  wire do_push = in_valid && in_ready;
  wire do_load = (count_reg != '0) && (!out_valid_reg || out_ready);

  assign in_ready  = count_reg < LVL_W'(DEPTH);
  assign out_valid = out_valid_reg;
  assign out_data  = out_data_reg;
  assign level     = count_reg;

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wptr_reg      <= '0;
      rptr_reg      <= '0;
      count_reg     <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else begin
      if (do_push) wptr_reg <= wptr_reg + AW'(1);
      if (do_load) rptr_reg <= rptr_reg + AW'(1);
      count_reg <= count_reg + LVL_W'(do_push) - LVL_W'(do_load);
      if (do_load) begin
        out_valid_reg <= 1'b1;
        out_data_reg  <= mem[rptr_reg];
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end
endmodule // ebl_fifo

//--- src/ebl_lane_sizer.sv
`timescale 1ns/1ps
module ebl_lane_sizer (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             req_valid,
  input  wire ebl_pkg::ebl_req_t req,
  output logic                  req_ready,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [31:0]           rd_data,
  output logic                  narrow_mode,
  input  wire logic             narrow_bus_select,
  output logic [31:2]           bus_addr,
  output logic                  bus_start_n,
  output logic                  bus_read,
  input  wire logic             bus_ready_n,
  input  wire logic [31:0]      data_in,
  output logic [31:0]           data_out,
  output logic                  data_lo_oe_n,
  output logic                  data_hi_oe_n,
  output logic                  lane0_enable_n,
  output logic                  lane1_enable_n,
  output logic                  lane2_enable_n_or_upper_lane_flag,
  output logic                  lane3_enable_n_or_halfword_address_line
);

  // ==========================================================
  // Pin synchronisers; stage one feeds stage two only
  logic [31:0] din_s1_reg;
  logic [31:0] din_s2_reg;
  logic        rdy_s1_reg;
  logic        rdy_s2_reg;
  logic        sel_s1_reg;
  logic        sel_s2_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      din_s1_reg <= ebl_pkg::WORD_ZERO;
      din_s2_reg <= ebl_pkg::WORD_ZERO;
      rdy_s1_reg <= 1'b1;
      rdy_s2_reg <= 1'b1;
      sel_s1_reg <= 1'b0;
      sel_s2_reg <= 1'b0;
    end else begin
      din_s1_reg <= data_in;
      din_s2_reg <= din_s1_reg;
      rdy_s1_reg <= bus_ready_n;
      rdy_s2_reg <= rdy_s1_reg;
      sel_s1_reg <= narrow_bus_select;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  // ==========================================================
  // Width capture once the synchroniser has settled after reset
  // Later pin changes are never looked at, so a stray toggle is harmless
  logic [1:0] cfg_cnt_reg;
  logic       cfg_done_reg;
  logic       narrow_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_cnt_reg  <= 2'h0;
      cfg_done_reg <= 1'b0;
      narrow_reg   <= 1'b0;
    end else if (!cfg_done_reg) begin
      cfg_cnt_reg <= cfg_cnt_reg + 2'h1;
      if (cfg_cnt_reg == ebl_pkg::CFG_SETTLE) begin
        cfg_done_reg <= 1'b1;
        narrow_reg   <= sel_s2_reg;
      end
    end
  end

  // ==========================================================
  // Read data buffer
  logic        push;
  logic [31:0] push_data;
  logic        fifo_in_ready;
  logic [5:0]  fifo_level;

  ebl_fifo #(
    .WIDTH (ebl_pkg::FIFO_WIDTH),
    .DEPTH (ebl_pkg::FIFO_DEPTH),
    .LVL_W (ebl_pkg::FIFO_LVL_W)
  ) u_rd_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data),
    .level     (fifo_level)
  );

  // ==========================================================
  // Sequencer
  ebl_pkg::ebl_state_t state_reg;
  ebl_pkg::ebl_state_t state_next;
  ebl_pkg::ebl_req_t   req_reg;
  logic                phase_reg;
  logic                phase_next;
  logic [2:0]          beat_reg;
  logic [2:0]          beat_next;
  logic [15:0]         low_reg;
  logic [15:0]         low_next;
  logic                req_ready_reg;
  logic                push_raw;

  wire take      = req_valid && req_ready_reg;
  wire rdy       = !rdy_s2_reg;
  wire is_burst  = req.size == ebl_pkg::SZ_BURST;
  wire [2:0] burst_last = narrow_reg ? ebl_pkg::NARROW_BURST_LAST
                                     : ebl_pkg::WIDE_BURST_LAST;

  // Bursts are line fills: read only, aligned to offset 0
  ebl_pkg::ebl_req_t req_take;
  always_comb begin
    req_take = req;
    if (is_burst) begin
      req_take.write     = 1'b0;
      req_take.addr[1:0] = 2'h0;
    end
  end

  wire ebl_pkg::ebl_req_t req_next = take ? req_take : req_reg;

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    beat_next  = beat_reg;
    low_next   = low_reg;
    push_raw   = 1'b0;
    push_data  = din_s2_reg;
    unique case (state_reg)
      ebl_pkg::ST_IDLE: begin
        if (take) begin
          state_next = ebl_pkg::ST_ADDR;
          phase_next = 1'b0;
          beat_next  = 3'h0;
        end
      end
      ebl_pkg::ST_ADDR: begin
        if (req_reg.size == ebl_pkg::SZ_BURST) begin
          state_next = ebl_pkg::ST_BURST;
        end else if (narrow_reg && req_reg.size == ebl_pkg::SZ_WORD) begin
          state_next = ebl_pkg::ST_WORD1;
        end else begin
          state_next = ebl_pkg::ST_SINGLE;
        end
      end
      ebl_pkg::ST_SINGLE: begin
        if (rdy) begin
          push_raw   = !req_reg.write;
          push_data  = narrow_reg ? {din_s2_reg[15:0], din_s2_reg[15:0]}
                                  : din_s2_reg;
          state_next = ebl_pkg::ST_IDLE;
        end
      end
      ebl_pkg::ST_WORD1: begin
        if (rdy) begin
          low_next   = din_s2_reg[15:0];
          phase_next = 1'b1;
          state_next = ebl_pkg::ST_WORD2;
        end
      end
      ebl_pkg::ST_WORD2: begin
        if (rdy) begin
          push_raw   = !req_reg.write;
          push_data  = {din_s2_reg[15:0], low_reg};
          state_next = ebl_pkg::ST_IDLE;
        end
      end
      ebl_pkg::ST_BURST: begin
        if (rdy) begin
          beat_next = beat_reg + 3'h1;
          if (narrow_reg) begin
            phase_next = !phase_reg;
            low_next   = phase_reg ? low_reg : din_s2_reg[15:0];
            push_raw   = phase_reg;
            push_data  = {din_s2_reg[15:0], low_reg};
          end else begin
            push_raw = 1'b1;
          end
          if (beat_reg == burst_last) begin
            state_next = ebl_pkg::ST_IDLE;
          end
        end
      end
    endcase
  end

  assign push = push_raw && fifo_in_ready;

  // Room is checked before a request is taken: a bus cycle cannot stall mid-beat
  wire room       = fifo_level <= ebl_pkg::FIFO_ROOM_LIMIT;
  wire active_nx  = state_next != ebl_pkg::ST_IDLE;
  wire ready_nx   = cfg_done_reg && !active_nx && room;

  // ==========================================================
  // Lane and dual-pin decode
  wire [1:0] a_nx = req_next.addr[1:0];
  logic [3:0] wide_lanes;
  logic [3:0] narrow_pins;

  always_comb begin
    unique case (req_next.size)
      ebl_pkg::SZ_BYTE: wide_lanes = ~(ebl_pkg::LANE_ONE << a_nx);
      ebl_pkg::SZ_HALF: wide_lanes = a_nx[1] ? ebl_pkg::LANES_HALF_HI
                                             : ebl_pkg::LANES_HALF_LO;
      ebl_pkg::SZ_WORD,
      ebl_pkg::SZ_BURST: wide_lanes = ebl_pkg::LANES_ALL;
    endcase
  end

  // Order: halfword address line, upper-lane flag, lane 1, lane 0
  always_comb begin
    unique case (req_next.size)
      ebl_pkg::SZ_BYTE: narrow_pins = {a_nx[1], 1'b1, !a_nx[0], a_nx[0]};
      ebl_pkg::SZ_HALF: narrow_pins = {a_nx[1], 1'b1, 2'b00};
      ebl_pkg::SZ_WORD,
      ebl_pkg::SZ_BURST: narrow_pins = {phase_next, 3'b000};
    endcase
  end

  wire [3:0] pins_nx = !active_nx  ? ebl_pkg::LANES_OFF :
                       narrow_reg ? narrow_pins : wide_lanes;

  // ==========================================================
  // Write data steering
  wire        hi_sel   = (req_next.size == ebl_pkg::SZ_WORD) ? phase_next : a_nx[1];
  wire [15:0] half_out = hi_sel ? req_next.wdata[31:16] : req_next.wdata[15:0];
  wire [31:0] dout_nx  = narrow_reg ? {ebl_pkg::HALF_ZERO, half_out} : req_next.wdata;
  wire        drive_nx = active_nx && req_next.write;

  // ==========================================================
  // Registers
  logic [3:0]  pins_reg;
  logic [31:2] addr_reg;
  logic        start_n_reg;
  logic        read_reg;
  logic [31:0] dout_reg;
  logic        lo_oe_n_reg;
  logic        hi_oe_n_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= ebl_pkg::ST_IDLE;
      req_reg       <= '0;
      phase_reg     <= 1'b0;
      beat_reg      <= 3'h0;
      low_reg       <= ebl_pkg::HALF_ZERO;
      req_ready_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      req_reg       <= req_next;
      phase_reg     <= phase_next;
      beat_reg      <= beat_next;
      low_reg       <= low_next;
      req_ready_reg <= ready_nx;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pins_reg    <= ebl_pkg::LANES_OFF;
      addr_reg    <= '0;
      start_n_reg <= 1'b1;
      read_reg    <= 1'b1;
      dout_reg    <= ebl_pkg::WORD_ZERO;
      lo_oe_n_reg <= 1'b1;
      hi_oe_n_reg <= 1'b1;
    end else begin
      pins_reg    <= pins_nx;
      addr_reg    <= req_next.addr[31:2];
      start_n_reg <= state_next != ebl_pkg::ST_ADDR;
      read_reg    <= !drive_nx;
      dout_reg    <= dout_nx;
      lo_oe_n_reg <= !drive_nx;
      hi_oe_n_reg <= !(drive_nx && !narrow_reg);
    end
  end

  // ==========================================================
  // Outputs
  assign req_ready                               = req_ready_reg;
  assign narrow_mode                             = narrow_reg;
  assign bus_addr                                = addr_reg;
  assign bus_start_n                             = start_n_reg;
  assign bus_read                                = read_reg;
  assign data_out                                = dout_reg;
  assign data_lo_oe_n                            = lo_oe_n_reg;
  assign data_hi_oe_n                            = hi_oe_n_reg;
  assign lane0_enable_n                          = pins_reg[0];
  assign lane1_enable_n                          = pins_reg[1];
  assign lane2_enable_n_or_upper_lane_flag       = pins_reg[2];
  assign lane3_enable_n_or_halfword_address_line = pins_reg[3];

endmodule // ebl_lane_sizer

//--- bench/ebl_lane_sizer_properties.sv
`timescale 1ns/1ps
// ========
// Lane, width and start-pulse checks
module ebl_chk (
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic              req_valid,
  input wire ebl_pkg::ebl_req_t req,
  input wire logic              req_ready,
  input wire logic              narrow_mode,
  input wire logic              bus_start_n,
  input wire logic [31:0]       data_out,
  input wire logic              data_hi_oe_n,
  input wire logic              lane0_enable_n,
  input wire logic              lane1_enable_n,
  input wire logic              lane2_enable_n_or_upper_lane_flag,
  input wire logic              lane3_enable_n_or_halfword_address_line
);
  wire logic [3:0] ln = {lane3_enable_n_or_halfword_address_line,
    lane2_enable_n_or_upper_lane_flag, lane1_enable_n, lane0_enable_n};
  wire logic       tk = req_valid && req_ready;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_take(ebl_pkg::ebl_size_t s);
    tk && req.size == s;
  endsequence
  sequence s_addr_state;
    !bus_start_n ##1 bus_start_n;
  endsequence
  property p_start; tk |=> s_addr_state; endproperty
  property p_wbyte;
    s_take(ebl_pkg::SZ_BYTE) ##0 !narrow_mode |=> ln == ~(4'h1 << $past(req.addr[1:0]));
  endproperty
  property p_whalf;
    s_take(ebl_pkg::SZ_HALF) ##0 !narrow_mode |=> ln == ($past(req.addr[1]) ? 4'h3 : 4'hC);
  endproperty
  property p_wburst; s_take(ebl_pkg::SZ_BURST) ##0 !narrow_mode |=> (ln == 4'h0)[*5]; endproperty
  property p_nbyte;
    s_take(ebl_pkg::SZ_BYTE) ##0 narrow_mode |=>
      ln == {$past(req.addr[1]), 1'b1, ~$past(req.addr[0]), $past(req.addr[0])};
  endproperty
  property p_nhalf;
    s_take(ebl_pkg::SZ_HALF) ##0 narrow_mode |=> ln == {$past(req.addr[1]), 3'h4};
  endproperty
  property p_nword; s_take(ebl_pkg::SZ_WORD) ##0 narrow_mode |=> (ln == 4'h0)[*2]; endproperty
  property p_nburst; s_take(ebl_pkg::SZ_BURST) ##0 narrow_mode |=> (ln[2:0] == 3'h0)[*8]; endproperty
  property p_nhi; narrow_mode |-> data_hi_oe_n && data_out[31:16] == 16'h0; endproperty
  a_start: assert property (p_start) else $error("address state not one cycle");
  a_wbyte: assert property (p_wbyte) else $error("wide byte lanes");
  a_whalf: assert property (p_whalf) else $error("wide halfword lanes");
  a_wburst: assert property (p_wburst) else $error("wide burst lanes");
  a_nbyte: assert property (p_nbyte) else $error("narrow byte lanes");
  a_nhalf: assert property (p_nhalf) else $error("narrow halfword lanes");
  a_nword: assert property (p_nword) else $error("narrow word lanes");
  a_nburst: assert property (p_nburst) else $error("narrow burst lanes");
  a_nhi: assert property (p_nhi) else $error("upper lines driven in narrow mode");
endmodule // ebl_chk

//--- bench/ebl_mem_model.sv
`timescale 1ns/1ps
// ========
// Far side memory
module ebl_mem (
  input  wire logic        mclk,
  input  wire logic        bus_start_n,
  input  wire logic [31:0] data_out,
  input  wire logic        data_lo_oe_n,
  input  wire logic [3:0]  ln,
  output logic             bus_ready_n,
  output logic [31:0]      data_in
);
  int          dly = 0;
  int          cnt = 0;
  logic [15:0] pat;
  logic [31:0] wq[$];
  initial begin
    bus_ready_n = 1'b1;
    data_in = 32'h5A5A_A5A5;
    forever begin
      @(posedge mclk);
      #5;
      bus_ready_n = 1'b1;
      // Released lines keep moving so stale data never matches
      data_in = ~data_in;
      if (!bus_start_n) begin
        pat = 16'hC000;
        cnt = dly;
      end else if (ln != 4'hF && cnt > 0) begin
        cnt--;
      end else if (ln != 4'hF) begin
        bus_ready_n = 1'b0;
        data_in = {~pat, pat};
        if (!data_lo_oe_n) wq.push_back(data_out);
        pat++;
        // Sync lag: next beat only once the last one has been seen
        cnt = dly + 5;
      end
    end
  end
endmodule // ebl_mem

//--- bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
  logic              mclk, rstn, req_valid, req_ready, rd_valid, rd_ready, nsel;
  logic              narrow_mode, bus_start_n, bus_read, bus_ready_n;
  logic              lo_oe_n, hi_oe_n, l0, l1, l2, l3;
  logic [31:0]       rd_data, data_out, data_in;
  logic [31:2]       bus_addr;
  ebl_pkg::ebl_req_t req;
  wire logic [3:0]   ln = {l3, l2, l1, l0};
  logic [31:0]       rq[$];
  int                err_count = 0, checks_done = 0, m, k, acc;
  bit                ok;
  // Write, size, offset, wide lanes, narrow lanes
  logic [19:0] rows [10] = '{20'h000E6, 20'h001D5, 20'h102BE, 20'h0037D, 20'h110C4,
                             20'h0123C, 20'h1123C, 20'h12000, 20'h02000, 20'h03000};
  ebl_lane_sizer uut (.mclk(mclk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .narrow_mode(narrow_mode), .narrow_bus_select(nsel), .bus_addr(bus_addr),
    .bus_start_n(bus_start_n), .bus_read(bus_read), .bus_ready_n(bus_ready_n),
    .data_in(data_in), .data_out(data_out), .data_lo_oe_n(lo_oe_n), .data_hi_oe_n(hi_oe_n),
    .lane0_enable_n(l0), .lane1_enable_n(l1), .lane2_enable_n_or_upper_lane_flag(l2),
    .lane3_enable_n_or_halfword_address_line(l3));
  ebl_mem mem (.mclk(mclk), .bus_start_n(bus_start_n), .data_out(data_out),
    .data_lo_oe_n(lo_oe_n), .ln(ln), .bus_ready_n(bus_ready_n), .data_in(data_in));
  always @(posedge mclk) if (rd_valid === 1'b1 && rd_ready) rq.push_back(rd_data);
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_req(input ebl_pkg::ebl_req_t r, output bit taken);
    int t;
    taken = 0;
    req = r;
    req_valid = 1'b1;
    for (t = 0; t < 200 && !taken; t++) begin taken = req_ready; @(posedge mclk); #5; end
    req_valid = 1'b0;
  endtask
  task automatic run_row(input logic [19:0] row, input logic n);
    ebl_pkg::ebl_req_t r;
    int                t, nb;
    logic [15:0]       p;
    logic [15:0]       h;
    logic [31:0]       e;
    r = {row[16], ebl_pkg::ebl_size_t'(row[13:12]), {28'h0000400, row[11:8]}, 32'hB00D_A11E};
    nb = (r.size == ebl_pkg::SZ_BURST) ? 4 : 1;
    mem.wq.delete();
    rq.delete();
    do_req(r, ok);
    `CHK(ok, 1'b1)
    `CHK(ln, n ? row[3:0] : row[7:4])
    `CHK(bus_addr, r.addr[31:2])
    `CHK({bus_read, lo_oe_n, hi_oe_n}, {!r.write, !r.write, !r.write || n})
    for (t = 0; t < 200 && !req_ready; t++) begin @(posedge mclk); #5; end
    if (r.write) begin
      `CHK(mem.wq.size(), (n && r.size == ebl_pkg::SZ_WORD) ? 2 : 1)
      for (t = 0; t < mem.wq.size(); t++) begin
        h = (t == 1 || r.addr[1]) ? r.wdata[31:16] : r.wdata[15:0];
        `CHK(mem.wq[t], n ? {16'h0, h} : r.wdata)
      end
    end else begin
      for (t = 0; t < 60 && rq.size() < nb; t++) begin @(posedge mclk); #5; end
      `CHK(rq.size(), nb)
      for (t = 0; t < rq.size(); t++) begin
        p = 16'hC000 + ((n && r.size >= ebl_pkg::SZ_WORD) ? 2 * t : t);
        e = n ? (r.size >= ebl_pkg::SZ_WORD ? {p + 16'h1, p} : {p, p}) : {~p, p};
        `CHK(rq[t], e)
      end
    end
    $display("row %h done", row);
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    summarize();
  end
  initial begin
    rstn = 1'b0; req_valid = 1'b0; req = '0; rd_ready = 1'b1; nsel = 1'b0;
    for (m = 0; m < 2; m++) begin
      rstn = 1'b0;
      nsel = m[0];
      repeat (3) @(posedge mclk);
      #5;
      `CHK({req_ready, ln, bus_start_n}, 6'h1F)
      rstn = 1'b1;
      for (k = 0; k < 20 && !req_ready; k++) begin @(posedge mclk); #5; end
      `CHK(narrow_mode, nsel)
      $display("reset %0d done", m);
      mem.dly = 3 * m;
      foreach (rows[i]) run_row(rows[i], nsel);
    end
    // Fill the read buffer with a stalled core until requests are refused
    // Output stage holds one word, so eight bursts fit below the room limit and the ninth waits
    rd_ready = 1'b0;
    rq.delete();
    acc = 0;
    for (k = 0; k < 9; k++) begin
      do_req({1'b0, ebl_pkg::SZ_BURST, 32'h0000_4003, 32'h0}, ok);
      acc += ok;
      @(posedge mclk);
      #5;
    end
    `CHK(acc, 8)
    rd_ready = 1'b1;
    for (k = 0; k < 100 && rq.size() < 32; k++) begin @(posedge mclk); #5; end
    `CHK(rq.size(), 32)
    `CHK(rq[27], 32'hC007_C006)
    $display("buffer fill done");
    summarize();
  end
endmodule // tb_top
bind ebl_lane_sizer ebl_chk chk (.mclk, .rstn, .req_valid, .req, .req_ready, .narrow_mode,
  .bus_start_n, .data_out, .data_hi_oe_n, .lane0_enable_n, .lane1_enable_n,
  .lane2_enable_n_or_upper_lane_flag, .lane3_enable_n_or_halfword_address_line);
